// >>> design/bus_area_pkg.sv
// shared constants and carrier types for the bus area configuration block
package bus_area_pkg;

    // ***************************************************
    // register byte offsets on the apb
    // ***************************************************
    localparam logic [11:0] ADDR_BUS_CONTROL_ONE = 12'h000;
    localparam logic [11:0] ADDR_BUS_WIDTH       = 12'h004;
    localparam logic [11:0] ADDR_IDLE_CYCLE      = 12'h008;
    localparam logic [11:0] ADDR_STATUS          = 12'h00c;

    // ***************************************************
    // power-on values and writable masks
    // ***************************************************
    localparam logic [15:0] BCO_RESET = 16'h0000;
    localparam logic [15:0] BWC_RESET = 16'h3ffc;
    localparam logic [15:0] ICC_RESET = 16'h3fff;
    localparam logic [15:0] BCO_WMASK = 16'h37ff; // 15,14,11 not writable
    localparam logic [15:0] BWC_WMASK = 16'h3ffd; // 15,14,1 reserved
    localparam logic [15:0] ICC_WMASK = 16'h3fff; // 15 handled apart

    // ***************************************************
    // field positions
    // ***************************************************
    localparam int BCO_ENDIAN_BIT  = 11;
    localparam int BCO_AREA5_CARD  = 1;
    localparam int BCO_AREA6_CARD  = 0;
    localparam int BCO_TYPE_LSB    = 2;
    localparam int BWC_PORT_BIT    = 0;
    localparam int BWC_WIDTH_LSB   = 2;
    localparam int ICC_WAIT_SEL    = 15;
    localparam int NUM_AREAS       = 7;

    // memory type codes for areas 2 and 3
    localparam logic [2:0] TYPE_BOTH_DRAM  = 3'h5;
    localparam logic [2:0] TYPE_AREA3_DRAM = 3'h4;

    // ***************************************************
    // carriers
    // ***************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic       valid; // bus cycle wants to start
        logic [2:0] area;  // target area 0..6
        logic       write; // 1 write, 0 read
    } bus_cycle_t;

endpackage

// >>> design/idle_gap_counter.sv
// down counter that times the idle gap between two bus cycles
`timescale 1ns/1ns
module idle_gap_counter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [1:0] count,
    output logic            done
);
    import bus_area_pkg::*;

    typedef struct packed {
        logic [1:0] cnt;  // idle cycles still to run
        logic       done; // high in the last idle cycle
    } gap_state_t;

    gap_state_t s;
    gap_state_t next_s;

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (load) begin
            next_s.cnt = count;
            // a one-cycle gap is already in its last cycle
            next_s.done = (count == 2'h1);
        end else if (s.cnt != 2'h0) begin
            next_s.cnt = s.cnt - 2'h1;
            // flag one edge early: the consumer registers it once more
            next_s.done = (s.cnt == 2'h2);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;
endmodule

// >>> design/wait_edge_sampler.sv
// samples the external wait input on the chosen bus clock edge
`timescale 1ns/1ns
module wait_edge_sampler (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic wait_n_in,
    input  wire logic falling_sel,
    output logic      wait_seen
);
    import bus_area_pkg::*;

    typedef struct packed {
        logic seen; // wait request as seen by the bus
    } wait_state_t;

    wait_state_t s;
    wait_state_t next_s;
    logic        fall_sample; // half-cycle sample, tolerates async input

    // falling edge catch leaves the source half a cycle less settling
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_sample <= 1'b0;
        end else begin
            fall_sample <= !wait_n_in;
        end
    end

    // pick the sample of the selected edge
    always_comb begin
        next_s      = s;
        next_s.seen = falling_sel ? fall_sample : !wait_n_in;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wait_seen = s.seen;
endmodule

// >>> design/bus_area_config_regs.sv
// bus area configuration registers with idle gap and pin reuse logic
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module bus_area_config_regs #(
    parameter bit HAS_WAIT_SEL = 1'b1 // revision has edge select
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire bus_area_pkg::apb_req_t  apb_req,
    output bus_area_pkg::apb_rsp_t       apb_rsp,
    input  wire logic                    endian_pin_in,
    input  wire logic                    second_row_strobe_n,
    input  wire logic                    card_enable_2a_n,
    input  wire logic                    card_enable_2b_n,
    input  wire bus_area_pkg::bus_cycle_t cyc,
    output logic                         cyc_go,
    output logic                         cyc_gap,
    input  wire logic                    wait_n_in,
    output logic                         wait_seen,
    output logic                         endian_pin_out,
    output logic                         endian_pin_oe,
    output logic                         mode_pin_three_out,
    output logic                         mode_pin_three_oe,
    output logic                         mode_pin_four_out,
    output logic                         mode_pin_four_oe,
    output logic                         dram_area2,
    output logic                         dram_area3,
    output logic                         lane_port_mode,
    output logic [11:0]                  area_width,
    output logic                         wait_falling
);
    import bus_area_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic [15:0] bco;         // bus_control_one
        logic [15:0] bwc;         // bus_width_control
        logic [15:0] icc;         // idle_cycle_control, bit15 hidden
        logic        endian_done; // strap caught after reset
        apb_rsp_t    rsp;         // bus answer
        logic [2:0]  last_area;   // area of previous bus cycle
        logic        last_read;   // previous cycle was a read
        logic        last_valid;  // any cycle seen yet
        logic        gap_pending; // waiting for idle gap to end
        logic        go;          // start pulse to bus engine
        logic        ep_out;      // endian pin level
        logic        ep_oe;       // endian pin driven
        logic        m3_out;      // mode pin three level
        logic        m3_oe;       // mode pin three driven
        logic        m4_out;      // mode pin four level
        logic        m4_oe;       // mode pin four driven
        logic        dram2;       // area 2 is dram
        logic        dram3;       // area 3 is dram
        logic        port_mode;   // upper mid lane is a port
    } cfg_state_t;

    cfg_state_t s;
    cfg_state_t next_s;

    logic        setup;       // apb setup phase
    logic        access_done; // apb access completes this edge
    logic        mapped;      // address hits a register
    logic [15:0] rd_value;    // read mux result
    logic [15:0] wdata;       // low half of write data
    logic [1:0]  idle_field [0:7]; // idle count per area
    logic [1:0]  need;        // idle cycles for this request
    logic        accept;      // new bus cycle taken now
    logic        gap_load;    // start the idle counter
    logic        gap_done;    // idle gap ran out
    logic [2:0]  bus_type;    // memory type field

    // ***************************************************
    // apb decode
    // ***************************************************
    assign setup = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable
                         && s.rsp.pready;
    assign wdata = apb_req.pwdata[15:0];
    assign bus_type = s.bco[BCO_TYPE_LSB +: 3];

    // address hit check
    always_comb begin
        unique case (apb_req.paddr)
            ADDR_BUS_CONTROL_ONE,
            ADDR_BUS_WIDTH,
            ADDR_IDLE_CYCLE,
            ADDR_STATUS: mapped = 1'b1;
            default:     mapped = 1'b0; // unmapped, slave error
        endcase
    end

    // read mux, reserved and write-only bits read zero
    always_comb begin
        unique case (apb_req.paddr)
            ADDR_BUS_CONTROL_ONE: rd_value = s.bco;
            ADDR_BUS_WIDTH:       rd_value = s.bwc;
            // edge select is write-only, never visible
            ADDR_IDLE_CYCLE:      rd_value = {2'h0, s.icc[13:0]};
            ADDR_STATUS:          rd_value = {10'h0, s.gap_pending,
                                              s.last_valid, s.last_read,
                                              s.last_area};
            default:              rd_value = 16'h0;
        endcase
    end

    // ***************************************************
    // idle field per area
    // ***************************************************
    for (genvar a = 0; a < 8; a++) begin : g_idle
        if (a < NUM_AREAS) begin : g_real
            assign idle_field[a] = s.icc[2*a +: 2];
        end else begin : g_none
            assign idle_field[a] = 2'h0; // no area 7
        end
    end

    // ***************************************************
    // idle gap decision
    // ***************************************************
    // gap after leaving an area, or read then write in one area
    always_comb begin
        need = 2'h0;
        if (s.last_valid && ((cyc.area != s.last_area)
            || (s.last_read && cyc.write))) begin
            need = idle_field[s.last_area];
        end
    end

    // one request at a time; new ones wait while a gap runs
    assign accept = cyc.valid && !s.gap_pending && !s.go;
    assign gap_load = accept && (need != 2'h0);

    idle_gap_counter u_gap (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (gap_load),
        .count   (need),
        .done    (gap_done)
    );

    wait_edge_sampler u_wait (
        .pclk        (pclk),
        .presetn     (presetn),
        .wait_n_in   (wait_n_in),
        .falling_sel (s.icc[ICC_WAIT_SEL]),
        .wait_seen   (wait_seen)
    );

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        next_s = s;
        next_s.rsp.pready  = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        next_s.go = 1'b0;
        // answer prepared in setup, so access lasts one cycle
        if (setup) begin
            next_s.rsp.pready  = 1'b1;
            next_s.rsp.pslverr = !mapped;
            next_s.rsp.prdata  = {16'h0, rd_value};
        end
        // writes land only at the completing access edge
        if (access_done && apb_req.pwrite && mapped) begin
            unique case (apb_req.paddr)
                ADDR_BUS_CONTROL_ONE: begin
                    next_s.bco = (s.bco & ~BCO_WMASK)
                                 | (wdata & BCO_WMASK);
                end
                ADDR_BUS_WIDTH: begin
                    next_s.bwc = wdata & BWC_WMASK;
                end
                ADDR_IDLE_CYCLE: begin
                    next_s.icc = wdata & ICC_WMASK;
                    // bit 14 stays zero; bit 15 only if present
                    if (HAS_WAIT_SEL) begin
                        next_s.icc[ICC_WAIT_SEL] = wdata[ICC_WAIT_SEL];
                    end else begin
                        next_s.icc[ICC_WAIT_SEL] = 1'b0;
                    end
                end
                default: begin
                    next_s.bco = s.bco; // status is read-only
                end
            endcase
        end
        // strap caught once, first clock after reset release
        if (!s.endian_done) begin
            next_s.bco[BCO_ENDIAN_BIT] = endian_pin_in;
            next_s.endian_done = 1'b1;
        end
        // bus cycle bookkeeping
        if (accept) begin
            next_s.last_area  = cyc.area;
            next_s.last_read  = !cyc.write;
            next_s.last_valid = 1'b1;
            if (need == 2'h0) begin
                next_s.go = 1'b1;
            end else begin
                next_s.gap_pending = 1'b1;
            end
        end
        if (gap_done) begin
            next_s.gap_pending = 1'b0;
            next_s.go = 1'b1;
        end
        // pin reuse follows the register value just stored
        next_s.dram3 = (next_s.bco[BCO_TYPE_LSB +: 3] == TYPE_BOTH_DRAM)
                       || (next_s.bco[BCO_TYPE_LSB +: 3]
                           == TYPE_AREA3_DRAM);
        next_s.dram2 = (next_s.bco[BCO_TYPE_LSB +: 3]
                        == TYPE_BOTH_DRAM);
        next_s.ep_oe  = next_s.dram2;
        next_s.ep_out = second_row_strobe_n;
        next_s.m3_oe  = next_s.bco[BCO_AREA5_CARD];
        next_s.m3_out = card_enable_2a_n;
        next_s.m4_oe  = next_s.bco[BCO_AREA6_CARD];
        next_s.m4_out = card_enable_2b_n;
        next_s.port_mode = next_s.bwc[BWC_PORT_BIT];
    end

    // ***************************************************
    // state register, power-on values only
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.bco <= BCO_RESET;
            s.bwc <= BWC_RESET;
            s.icc <= ICC_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ***************************************************
    // outputs, all from flip-flops
    // ***************************************************
    assign apb_rsp            = s.rsp;
    assign cyc_go             = s.go;
    assign cyc_gap            = s.gap_pending;
    assign endian_pin_out     = s.ep_out;
    assign endian_pin_oe      = s.ep_oe;
    assign mode_pin_three_out = s.m3_out;
    assign mode_pin_three_oe  = s.m3_oe;
    assign mode_pin_four_out  = s.m4_out;
    assign mode_pin_four_oe   = s.m4_oe;
    assign dram_area2         = s.dram2;
    assign dram_area3         = s.dram3;
    assign lane_port_mode     = s.port_mode;
    assign area_width         = s.bwc[BWC_WIDTH_LSB +: 12];
    assign wait_falling       = s.icc[ICC_WAIT_SEL];

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dram_pair_flags: assert property (
        (bus_type == TYPE_BOTH_DRAM) |-> (dram_area2 && dram_area3)
    ) else $error("dram pair not flagged");

    a_row_strobe_pin: assert property (
        endian_pin_oe |-> (bus_type == TYPE_BOTH_DRAM)
    ) else $error("row strobe driven without dram pair");

    a_card_a_pin: assert property (
        mode_pin_three_oe == s.bco[BCO_AREA5_CARD]
    ) else $error("pin three drive does not match card bit");

    a_card_b_pin: assert property (
        mode_pin_four_oe == s.bco[BCO_AREA6_CARD]
    ) else $error("pin four drive does not match card bit");

    a_width_reset: assert property (
        !$past(presetn) |-> (s.bwc == BWC_RESET)
    ) else $error("width register wrong after reset");

    a_idle_reset: assert property (
        !$past(presetn) |-> (s.icc == ICC_RESET)
    ) else $error("idle register wrong after reset");

    a_width_reserved_zero: assert property (
        (setup && apb_req.paddr == ADDR_BUS_WIDTH)
        |=> (apb_rsp.prdata[15:14] == 2'h0 && !apb_rsp.prdata[1])
    ) else $error("reserved width bits read nonzero");

    a_edge_sel_hidden: assert property (
        (setup && apb_req.paddr == ADDR_IDLE_CYCLE)
        |=> (apb_rsp.prdata[15:14] == 2'h0)
    ) else $error("idle register top bits read nonzero");

    a_lane_port: assert property (
        lane_port_mode == s.bwc[BWC_PORT_BIT]
    ) else $error("port mode does not follow port bit");

    // exactly n idle cycles, then the start pulse
    a_idle_gap_len: assert property (
        (gap_load && need == 2'h3)
        |=> (cyc_gap && !cyc_go)[*3] ##1 (cyc_go && !cyc_gap)
    ) else $error("three-cycle gap has wrong length");

    a_idle_gap_one: assert property (
        (gap_load && need == 2'h1)
        |=> (cyc_gap && !cyc_go) ##1 (cyc_go && !cyc_gap)
    ) else $error("one-cycle gap has wrong length");

    a_no_gap_start: assert property (
        (accept && need == 2'h0) |=> (cyc_go && !cyc_gap)
    ) else $error("gapless cycle not started at once");

    a_go_single: assert property (
        cyc_go |=> !cyc_go
    ) else $error("start pulse longer than one cycle");

    a_card_pins_reset: assert property (
        !$past(presetn) |-> !(mode_pin_three_oe || mode_pin_four_oe)
    ) else $error("card pins driven after reset");

    a_edge_sel_absent: assert property (
        !HAS_WAIT_SEL |-> !wait_falling
    ) else $error("edge select set on revision without it");

endmodule

// >>> testbench/far_side_model.sv
// far side model: dram and card engines plus the external wait source
`timescale 1ns/1ns
module far_side_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic hold_wait,
    output logic      second_row_strobe_n,
    output logic      card_enable_2a_n,
    output logic      card_enable_2b_n,
    output logic      wait_n_in
);
    logic [2:0] pat; // strobe pattern, alternates between 3'h5 and 3'h2

    // ***************************************************
    // strobes change every cycle so a stuck pin shows up
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pat       <= 3'h5;
            wait_n_in <= 1'b1;
        end else begin
            pat       <= {pat[1:0], ~pat[2]};
            wait_n_in <= !hold_wait;
        end
    end

    assign second_row_strobe_n = pat[0];
    assign card_enable_2a_n    = pat[1];
    assign card_enable_2b_n    = pat[2];
endmodule

// >>> testbench/tb.sv
// self-checking bench for the bus area configuration registers
`timescale 1ns/1ns
module tb;
    import bus_area_pkg::*;
    logic        pclk;
    logic        presetn;
    apb_req_t    apb_req;     // register bus request
    apb_rsp_t    apb_rsp;     // register bus answer
    bus_cycle_t  cyc;         // bus cycle request
    logic        endian_pin_in;
    logic        hold_wait;   // asks the far side to hold wait
    logic        second_row_strobe_n, card_enable_2a_n, card_enable_2b_n;
    logic        wait_n_in, cyc_go, cyc_gap, wait_seen, wait_falling;
    logic        endian_pin_out, endian_pin_oe, lane_port_mode;
    logic        mode_pin_three_out, mode_pin_three_oe;
    logic        mode_pin_four_out, mode_pin_four_oe;
    logic        dram_area2, dram_area3;
    logic [11:0] area_width;
    int          error_cnt = 0;
    int          n_tests = 0;

    bus_area_config_regs bus_area_config_regs_inst (
        .pclk                (pclk),
        .presetn             (presetn),
        .apb_req             (apb_req),
        .apb_rsp             (apb_rsp),
        .endian_pin_in       (endian_pin_in),
        .second_row_strobe_n (second_row_strobe_n),
        .card_enable_2a_n    (card_enable_2a_n),
        .card_enable_2b_n    (card_enable_2b_n),
        .cyc                 (cyc),
        .cyc_go              (cyc_go),
        .cyc_gap             (cyc_gap),
        .wait_n_in           (wait_n_in),
        .wait_seen           (wait_seen),
        .endian_pin_out      (endian_pin_out),
        .endian_pin_oe       (endian_pin_oe),
        .mode_pin_three_out  (mode_pin_three_out),
        .mode_pin_three_oe   (mode_pin_three_oe),
        .mode_pin_four_out   (mode_pin_four_out),
        .mode_pin_four_oe    (mode_pin_four_oe),
        .dram_area2          (dram_area2),
        .dram_area3          (dram_area3),
        .lane_port_mode      (lane_port_mode),
        .area_width          (area_width),
        .wait_falling        (wait_falling)
    );

    far_side_model far_side_model_inst (
        .pclk                (pclk),
        .presetn             (presetn),
        .hold_wait           (hold_wait),
        .second_row_strobe_n (second_row_strobe_n),
        .card_enable_2a_n    (card_enable_2a_n),
        .card_enable_2b_n    (card_enable_2b_n),
        .wait_n_in           (wait_n_in)
    );

    // ***************************************************
    // clock, verdict and watchdog
    // ***************************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // hang guard, far beyond the roughly 130 cycles needed
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ***************************************************
    // apb master: setup, access until pready
    // ***************************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int i;
        @(posedge pclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= w;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= wd;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (apb_rsp.pready === 1'b1) break;
        end
        check(apb_rsp.pready, 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, x);
    endtask

    // one bus cycle; counts idle cycles before the go pulse
    task automatic bus_cycle(input logic [2:0] ar, input logic w,
                             input int gap);
        int n, i;
        n = 0;
        @(posedge pclk);
        cyc <= '{1'b1, ar, w};
        @(posedge pclk);
        cyc.valid <= 1'b0;
        for (i = 0; i < 8; i++) begin
            #1;
            if (cyc_go === 1'b1) break;
            n += int'(cyc_gap);
            @(posedge pclk);
        end
        check(cyc_go, 1'b1);
        check(n, gap);
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_reset();
        rd_chk(ADDR_BUS_WIDTH, 32'h3ffc);
        rd_chk(ADDR_IDLE_CYCLE, 32'h3fff);
        rd_chk(ADDR_BUS_CONTROL_ONE, 32'h0800);
        check(area_width, 12'hfff);
        check(lane_port_mode, 1'b0);
        check(wait_falling, 1'b0);
        check(mode_pin_three_oe, 1'b0);
        check(mode_pin_four_oe, 1'b0);
    endtask

    // reserved bits, width codes, port mode, upper half ignored
    task automatic t_width();
        logic [31:0] r;
        logic        e;
        wr(ADDR_BUS_WIDTH, 32'hffff_ffff);
        rd_chk(ADDR_BUS_WIDTH, 32'h3ffd);
        check(lane_port_mode, 1'b1);
        wr(ADDR_BUS_WIDTH, 32'h0000_2aa9);
        rd_chk(ADDR_BUS_WIDTH, 32'h2aa9);
        check(area_width, 12'haaa);
        wr(ADDR_BUS_WIDTH, 32'hffff_1554);
        rd_chk(ADDR_BUS_WIDTH, 32'h1554);
        check(area_width, 12'h555);
        check(lane_port_mode, 1'b0);
        apb(1'b1, 12'h010, 32'h0, r, e);
        check(e, 1'b1);
    endtask

    // card modes and dram pair drive the reused mode pins
    task automatic t_pins();
        int i;
        logic a, b, s;
        wr(ADDR_BUS_CONTROL_ONE, 32'h0003);
        wr(ADDR_BUS_WIDTH, 32'h3fac);
        wr(ADDR_BUS_CONTROL_ONE, 32'h0017);
        for (i = 0; i < 4; i++) begin
            @(posedge pclk);
            a = card_enable_2a_n;
            b = card_enable_2b_n;
            s = second_row_strobe_n;
            #1;
            check({mode_pin_three_oe, mode_pin_three_out}, {1'b1, a});
            check({mode_pin_four_oe, mode_pin_four_out}, {1'b1, b});
            check({endian_pin_oe, endian_pin_out}, {1'b1, s});
            check({dram_area2, dram_area3}, 2'b11);
        end
        wr(ADDR_BUS_CONTROL_ONE, 32'h0010);
        @(posedge pclk);
        #1;
        check({dram_area2, dram_area3, endian_pin_oe}, 3'b010);
        check({mode_pin_three_oe, mode_pin_four_oe}, 2'b00);
    endtask

    // idle gaps on area change and on read then write
    task automatic t_gap();
        int k;
        for (k = 0; k < 4; k++) begin
            wr(ADDR_IDLE_CYCLE, 32'(k) << 2);
            bus_cycle(3'h1, 1'b0, 0);
            bus_cycle(3'h2, 1'b0, k);
        end
        wr(ADDR_IDLE_CYCLE, 32'h0020);
        bus_cycle(3'h2, 1'b0, 0);
        bus_cycle(3'h2, 1'b1, 2);
        bus_cycle(3'h2, 1'b1, 0);
    endtask

    // both wait sample edges; the select bit never reads back
    task automatic t_wait();
        int k;
        for (k = 1; k >= 0; k--) begin
            wr(ADDR_IDLE_CYCLE, {16'h0, k[0], 15'h3fff});
            rd_chk(ADDR_IDLE_CYCLE, 32'h3fff);
            check(wait_falling, k[0]);
            @(posedge pclk);
            hold_wait <= 1'b1;
            repeat (4) @(posedge pclk);
            #1;
            check(wait_seen, 1'b1);
            @(posedge pclk);
            hold_wait <= 1'b0;
            repeat (4) @(posedge pclk);
            #1;
            check(wait_seen, 1'b0);
        end
    endtask

    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        cyc = '0;
        hold_wait = 1'b0;
        endian_pin_in = 1'b1; // strap high, seen in bit 11
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_width();
        t_pins();
        t_gap();
        t_wait();
        conclude();
    end
endmodule
